// ---- hw/spims_pkg.sv ----
// Constants, register map and carrier types of the serial peripheral port
`default_nettype none
package spims_pkg;
  // ---------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] SPIMS_IDX_CONTROL = 8'h2C;
  localparam logic [7:0] SPIMS_IDX_STATUS = 8'h2D;
  localparam logic [7:0] SPIMS_IDX_DATA = 8'h2E;
  localparam logic [7:0] SPIMS_IDX_PINDIR = 8'h2F;
  localparam logic [7:0] SPIMS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SPIMS_STATUS_RESET = 8'h00;
  localparam logic [4:0] SPIMS_PINDIR_RESET = 5'h00;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SPIMS_ST_DONE = 7;
  localparam int SPIMS_ST_WRITE_COLLISION_FLAG = 6;
  localparam int SPIMS_ST_DBL = 0;
  localparam int SPIMS_DIR_MOSI = 0;
  localparam int SPIMS_DIR_MISO = 1;
  localparam int SPIMS_DIR_SCK = 2;
  localparam int SPIMS_DIR_SS = 3;
  localparam int SPIMS_DIR_SSOUT = 4;
  // ---------------------------------------------------------------
  // Timing: SCK divisors indexed by {double speed, rate high, rate low}
  // ---------------------------------------------------------------
  localparam logic [7:0] SPIMS_DIVISOR [8] = '{8'h04, 8'h10, 8'h40, 8'h80,
                                               8'h02, 8'h08, 8'h20, 8'h40};
  localparam logic [3:0] SPIMS_LAST_EDGE = 4'hF;
  localparam logic [2:0] SPIMS_LAST_BIT = 3'h7;
  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic intEnable;
    logic portEnable;
    logic bitOrderLsb;
    logic masterSel;
    logic clockPolarity;
    logic clockPhase;
    logic rateHigh;
    logic rateLow;
  } spims_ctrl_t;
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss;
  } spims_pins_t;
endpackage
`default_nettype wire

// ---- hw/spims_port.sv ----
// Byte-wide serial peripheral port, master or slave, with AHB-Lite registers
//
// Function
// - Slave with select low is active; drives MISO only if configured output.
// - Slave select high: passive, reset bit counter, drop partial byte.
// - Master with select as output: pin is plain output, no serial effect.
// - Master with select input low: clear master bit, become slave.
// - Losing master mode this way sets the transfer-complete flag.
// - Stay slave until software sets master-select again.
// - Shift out on one SCK edge, sample on the opposite; modes 0 to 3.
// - Polarity bit sets SCK idle level and leading edge direction.
// - Phase bit picks sample on leading or on trailing edge.
// - Interrupt only with enable bit, transfer flag and global enable.
// - No serial operation unless port enable is one.
// - Bit order one sends LSB first, zero sends MSB first.
// - Master-select one means master, zero means slave.
// - Double speed and rate bits pick divisors 4,16,64,128,2,8,32,64.
// - Rate bits have no effect in slave operation.
// - Transfer-complete flag sets when a byte finishes.
// - Flag clears on interrupt acknowledge or status read then data access.
// - Data write during a transfer sets the write-collision flag.
// - Status read with collision set, then data access, clears both flags.
// - Status bits five to one read zero.
// - Double speed doubles SCK; shortest period two system clocks.
// - Data write starts a transfer; data read returns receive buffer.
// - Master clock runs exactly eight bits then stops and flags.
// - Transmit single buffered, receive double buffered.
//
// The AHB-Lite register port is this design's own decision.
`default_nettype none
module spims_port (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Processor interrupt context
  input wire logic globalIntEnable,
  input wire logic intVectorAck,
  output logic irqReq,
  // Serial pins
  input wire spims_pkg::spims_pins_t pinIn,
  output spims_pkg::spims_pins_t pinOut,
  output spims_pkg::spims_pins_t pinOe
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  spims_pkg::spims_pins_t syncA_q, syncB_q;
  logic sckDly_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      syncA_q <= '0;
      syncB_q <= '0;
      sckDly_q <= 1'b0;
    end else begin
      syncA_q <= pinIn;
      syncB_q <= syncA_q;
      sckDly_q <= syncB_q.sck;
    end
  end

  // ---------------------------------------------------------------
  // Bus address phase
  // ---------------------------------------------------------------
  spims_pkg::spims_ctrl_t ctrl_q;
  logic dblSpeed_q, done_q, write_collision_flag_q, armDone_q, armWcol_q;
  logic [4:0] pinDir_q;
  logic [7:0] rxBuf_q, shift_q, tx_q;
  logic aValid_q, aWrite_q;
  logic [7:0] aIdx_q;
  logic [31:0] hrdata_q;
  logic busAcc;
  logic [7:0] curIdx;
  logic [7:0] statusVal;
  assign busAcc = hsel & htrans[1] & hready;
  assign curIdx = haddr[9:2];
  assign statusVal = {done_q, write_collision_flag_q, 5'h00, dblSpeed_q};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aValid_q <= 1'b0;
      aWrite_q <= 1'b0;
      aIdx_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      aValid_q <= busAcc;
      aWrite_q <= hwrite;
      aIdx_q <= curIdx;
      if (busAcc && !hwrite) begin
        unique case (curIdx)
          spims_pkg::SPIMS_IDX_CONTROL: hrdata_q <= {24'h000000, ctrl_q};
          spims_pkg::SPIMS_IDX_STATUS: hrdata_q <= {24'h000000, statusVal};
          spims_pkg::SPIMS_IDX_DATA: hrdata_q <= {24'h000000, rxBuf_q};
          spims_pkg::SPIMS_IDX_PINDIR: hrdata_q <= {27'h0000000, pinDir_q};
          default: hrdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  // Zero wait states, always OKAY
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ---------------------------------------------------------------
  // Decoded accesses
  // ---------------------------------------------------------------
  logic wrPhase, ctrlWr, statWr, dataWr, dirWr, dataRd, statRd, dataAccess;
  assign wrPhase = aValid_q & aWrite_q;
  assign ctrlWr = wrPhase && aIdx_q == spims_pkg::SPIMS_IDX_CONTROL;
  assign statWr = wrPhase && aIdx_q == spims_pkg::SPIMS_IDX_STATUS;
  assign dataWr = wrPhase && aIdx_q == spims_pkg::SPIMS_IDX_DATA;
  assign dirWr = wrPhase && aIdx_q == spims_pkg::SPIMS_IDX_PINDIR;
  assign dataRd = busAcc && !hwrite && curIdx == spims_pkg::SPIMS_IDX_DATA;
  assign statRd = busAcc && !hwrite && curIdx == spims_pkg::SPIMS_IDX_STATUS;
  assign dataAccess = dataWr | dataRd;

  // ---------------------------------------------------------------
  // Mode and engine state
  // ---------------------------------------------------------------
  logic busy_q, sck_q, dout_q, doneEvt;
  logic [3:0] edgeCnt_q;
  logic [2:0] bitCnt_q;
  logic [7:0] divCnt_q;
  logic enabled, isMaster, ssLow, modeFault, inProgress;
  logic [2:0] rateCode;
  logic [7:0] halfDiv;
  assign enabled = ctrl_q.portEnable;
  assign isMaster = ctrl_q.masterSel;
  assign ssLow = !syncB_q.ss;
  // select input pulled low while master
  assign modeFault = enabled && isMaster && !pinDir_q[spims_pkg::SPIMS_DIR_SS] && ssLow;
  // transfer in progress in either role
  assign inProgress = busy_q | (!isMaster && bitCnt_q != 3'h0);
  // divisor pick, used only by master timing
  assign rateCode = {dblSpeed_q, ctrl_q.rateHigh, ctrl_q.rateLow};
  assign halfDiv = spims_pkg::SPIMS_DIVISOR[rateCode] >> 1;

  // ---------------------------------------------------------------
  // Control and pin-direction registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= spims_pkg::SPIMS_CONTROL_RESET;
      dblSpeed_q <= spims_pkg::SPIMS_STATUS_RESET[spims_pkg::SPIMS_ST_DBL];
      pinDir_q <= spims_pkg::SPIMS_PINDIR_RESET;
    end else begin
      if (ctrlWr) begin
        ctrl_q <= hwdata[7:0];
      end
      // master bit held clear until rewritten
      if (modeFault) begin
        ctrl_q.masterSel <= 1'b0;
      end
      if (statWr) begin
        dblSpeed_q <= hwdata[spims_pkg::SPIMS_ST_DBL];
      end
      if (dirWr) begin
        pinDir_q <= hwdata[4:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Shift engine
  // ---------------------------------------------------------------
  logic sckRise, sckFall, lead, trail, sampleEdge, setupEdge;
  logic tick, inBit, outBit;
  logic [7:0] shiftNext;
  assign sckRise = syncB_q.sck & !sckDly_q;
  assign sckFall = !syncB_q.sck & sckDly_q;
  assign tick = busy_q && divCnt_q == 8'h00;
  always_comb begin
    if (isMaster) begin
      // Master edges come from its own divider
      lead = tick && !edgeCnt_q[0];
      trail = tick && edgeCnt_q[0];
      inBit = syncB_q.miso;
    end else begin
      // leading edge is rising for low idle level
      lead = ctrl_q.clockPolarity ? sckFall : sckRise;
      trail = ctrl_q.clockPolarity ? sckRise : sckFall;
      inBit = syncB_q.mosi;
    end
    sampleEdge = ctrl_q.clockPhase ? trail : lead;
    setupEdge = ctrl_q.clockPhase ? lead : trail;
  end
  assign outBit = ctrl_q.bitOrderLsb ? shift_q[0] : shift_q[7];
  assign shiftNext = ctrl_q.bitOrderLsb ? {inBit, shift_q[7:1]} : {shift_q[6:0], inBit};
  assign doneEvt = enabled && !modeFault && (isMaster ? (tick && edgeCnt_q ==
    spims_pkg::SPIMS_LAST_EDGE) : (ssLow && sampleEdge && bitCnt_q == spims_pkg::SPIMS_LAST_BIT));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      sck_q <= 1'b0;
      dout_q <= 1'b0;
      edgeCnt_q <= 4'h0;
      bitCnt_q <= 3'h0;
      divCnt_q <= 8'h00;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
    end else if (!enabled || modeFault) begin
      busy_q <= 1'b0;
      edgeCnt_q <= 4'h0;
      bitCnt_q <= 3'h0;
      sck_q <= ctrl_q.clockPolarity;
      if (dataWr) begin
        shift_q <= hwdata[7:0];
        tx_q <= hwdata[7:0];
      end
    end else if (isMaster) begin
      bitCnt_q <= 3'h0;
      if (dataWr && !inProgress) begin
        shift_q <= hwdata[7:0];
        tx_q <= hwdata[7:0];
        dout_q <= ctrl_q.bitOrderLsb ? hwdata[0] : hwdata[7];
        busy_q <= 1'b1;
        edgeCnt_q <= 4'h0;
        divCnt_q <= halfDiv - 8'h01;
      end else if (busy_q) begin
        divCnt_q <= tick ? halfDiv - 8'h01 : divCnt_q - 8'h01;
        if (tick) begin
          // half period of one cycle at the fastest code
          sck_q <= !sck_q;
          edgeCnt_q <= edgeCnt_q + 4'h1;
          // sample and setup on opposite edges
          if (sampleEdge) begin
            shift_q <= shiftNext;
          end
          if (setupEdge) begin
            dout_q <= outBit;
          end
          if (edgeCnt_q == spims_pkg::SPIMS_LAST_EDGE) begin
            busy_q <= 1'b0;
          end
        end
      end else begin
        sck_q <= ctrl_q.clockPolarity;
        dout_q <= outBit;
      end
    end else begin
      busy_q <= 1'b0;
      sck_q <= ctrl_q.clockPolarity;
      if (!ssLow) begin
        // select high drops the partial byte
        bitCnt_q <= 3'h0;
        shift_q <= dataWr ? hwdata[7:0] : tx_q;
        dout_q <= outBit;
        if (dataWr) begin
          tx_q <= hwdata[7:0];
        end
      end else begin
        if (dataWr && !inProgress) begin
          shift_q <= hwdata[7:0];
          tx_q <= hwdata[7:0];
          dout_q <= ctrl_q.bitOrderLsb ? hwdata[0] : hwdata[7];
        end else if (sampleEdge) begin
          // edges seen on the synchronised clock
          shift_q <= shiftNext;
          bitCnt_q <= bitCnt_q + 3'h1;
        end
        if (setupEdge) begin
          dout_q <= outBit;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive buffer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rxBuf_q <= 8'h00;
    end else if (doneEvt) begin
      rxBuf_q <= (isMaster && !sampleEdge) ? shift_q : shiftNext;
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  logic clrDone, clrWcol;
  assign clrWcol = dataAccess && armWcol_q;
  assign clrDone = (dataAccess && (armDone_q || armWcol_q)) || intVectorAck;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      done_q <= spims_pkg::SPIMS_STATUS_RESET[spims_pkg::SPIMS_ST_DONE];
      write_collision_flag_q <= spims_pkg::SPIMS_STATUS_RESET[spims_pkg::SPIMS_ST_WRITE_COLLISION_FLAG];
      armDone_q <= 1'b0;
      armWcol_q <= 1'b0;
    end else begin
      if (doneEvt || modeFault) begin
        done_q <= 1'b1;
      end else if (clrDone) begin
        done_q <= 1'b0;
      end
      if (dataWr && inProgress && enabled) begin
        write_collision_flag_q <= 1'b1;
      end else if (clrWcol) begin
        write_collision_flag_q <= 1'b0;
      end
      if (statRd) begin
        armDone_q <= done_q;
        armWcol_q <= write_collision_flag_q;
      end else if (dataAccess) begin
        armDone_q <= 1'b0;
        armWcol_q <= 1'b0;
      end
    end
  end
  assign irqReq = ctrl_q.intEnable & done_q & globalIntEnable;

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  logic slaveActive;
  // slave active only with select low
  assign slaveActive = enabled && !isMaster && ssLow;
  always_comb begin
    pinOut.sck = sck_q;
    pinOut.mosi = dout_q;
    pinOut.miso = dout_q;
    pinOut.ss = pinDir_q[spims_pkg::SPIMS_DIR_SSOUT];
    if (enabled && !isMaster) begin
      // slave pins are inputs except MISO
      pinOe.sck = 1'b0;
      pinOe.mosi = 1'b0;
      pinOe.ss = 1'b0;
      pinOe.miso = slaveActive && pinDir_q[spims_pkg::SPIMS_DIR_MISO];
    end else begin
      pinOe.sck = pinDir_q[spims_pkg::SPIMS_DIR_SCK];
      pinOe.mosi = pinDir_q[spims_pkg::SPIMS_DIR_MOSI];
      pinOe.ss = pinDir_q[spims_pkg::SPIMS_DIR_SS];
      pinOe.miso = !enabled && pinDir_q[spims_pkg::SPIMS_DIR_MISO];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_fault_to_slave: assert property (@(posedge clk_sys) disable iff (!nrst)
    modeFault |=> !ctrl_q.masterSel && done_q)
    else $error("select low did not drop master mode");
  a_slave_reset: assert property (@(posedge clk_sys) disable iff (!nrst)
    (enabled && !isMaster && !ssLow) |=> bitCnt_q == 3'h0)
    else $error("slave bit counter not reset by select high");
  a_disabled_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    !enabled |=> !busy_q && !done_q || $past(done_q))
    else $error("engine ran while disabled");
  a_miso_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
    (enabled && pinOe.miso) |-> !isMaster && ssLow && pinDir_q[spims_pkg::SPIMS_DIR_MISO])
    else $error("MISO driven outside active slave");
  a_sck_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!busy_q && $past(!busy_q) && $stable(ctrl_q.clockPolarity)) |-> sck_q == ctrl_q.clockPolarity)
    else $error("SCK idle level wrong");
  a_write_collision_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    (dataWr && inProgress && enabled) |=> write_collision_flag_q)
    else $error("collision flag not set");
  a_done_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    doneEvt |=> done_q)
    else $error("transfer flag not set");
  a_fast_byte: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($rose(busy_q) && rateCode == 3'h4 && pinDir_q[spims_pkg::SPIMS_DIR_SS] && enabled)
    |-> busy_q[*8] ##1 busy_q[*8] ##1 !busy_q)
    else $error("double speed byte not sixteen cycles");
  a_ack_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    (intVectorAck && !doneEvt && !modeFault) |=> !done_q)
    else $error("vector acknowledge did not clear flag");
endmodule
`default_nettype wire

// ---- testbench/spims_peer.sv ----
// Behavioural external slave answering the port in master operation
`default_nettype none
module spims_peer (
  // Serial lines
  input wire logic sck,
  input wire logic mosi,
  input wire logic ssN,
  output logic miso,
  // Mode and data
  input wire logic [1:0] mode,
  input wire logic lsbFirst,
  input wire logic [7:0] txByte,
  output logic [7:0] rxByte
);
  timeunit 1ns;
  timeprecision 1ns;
  int outIdx;
  function automatic logic pick(input int k);
    return lsbFirst ? txByte[k] : txByte[7 - k];
  endfunction
  initial begin
    miso = 1'b0;
    rxByte = 8'h00;
    outIdx = 0;
  end
  // Released line shows the inverse, never a stale bit
  always @(posedge ssN) miso = ~miso;
  always @(negedge ssN) begin
    outIdx = 0;
    if (!mode[0]) begin
      miso = pick(0);
      outIdx = 1;
    end
  end
  // setup and sample on opposite edges
  always @(sck) begin
    if (!ssN) begin
      if ((sck != mode[1]) != mode[0]) begin
        rxByte = lsbFirst ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
      end else if (outIdx < 8) begin
        miso = pick(outIdx);
        outIdx++;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/test_spims_port.sv ----
// Self-checking bench for the serial peripheral port
`default_nettype none
module test_spims_port;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CTL = spims_pkg::SPIMS_IDX_CONTROL;
  localparam logic [7:0] STS = spims_pkg::SPIMS_IDX_STATUS;
  localparam logic [7:0] DAT = spims_pkg::SPIMS_IDX_DATA;
  localparam logic [7:0] DIR = spims_pkg::SPIMS_IDX_PINDIR;
  localparam int DIVS [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
  logic clk_sys = 1'b0;
  logic nrst, hsel, hwrite, hready, hreadyout, hresp, globalIntEnable, intVectorAck, irqReq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  spims_pkg::spims_pins_t pinIn, pinOut, pinOe;
  logic bSck, bMosi, bSs, peerMiso, sckL, mosiL, misoL, ssL, lsb, sckPrev;
  logic rdPend = 1'b0;
  logic [1:0] mode;
  logic [7:0] peerTx, peerRx, tx, rx, got;
  logic [31:0] expQ [$];
  int n_fail = 0, checks_done = 0, cyc = 0, togs = 0, lastT = 0, gapMin, gapMax;
  // ----
  // Wiring
  // ----
  always #5 clk_sys = ~clk_sys;
  assign hready = hreadyout;
  assign sckL = pinOe.sck ? pinOut.sck : bSck;
  assign mosiL = pinOe.mosi ? pinOut.mosi : bMosi;
  assign misoL = pinOe.miso ? pinOut.miso : peerMiso;
  assign ssL = pinOe.ss ? pinOut.ss : bSs;
  assign pinIn = {sckL, mosiL, misoL, ssL};
  spims_port dut (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .globalIntEnable(globalIntEnable), .intVectorAck(intVectorAck), .irqReq(irqReq),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
  spims_peer peer (.sck(sckL), .mosi(mosiL), .ssN(ssL), .miso(peerMiso), .mode(mode),
    .lsbFirst(lsb), .txByte(peerTx), .rxByte(peerRx));
  task automatic end_of_test;
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Read data is compared one cycle after its address phase
  always @(posedge clk_sys) begin
    if (rdPend) check(hrdata, expQ.pop_front());
    if (rdPend) check(hresp, 1'b0);
    rdPend <= hsel && htrans[1] && !hwrite && hready;
  end
  // Gaps between SCK edges, first edge left out
  always @(posedge clk_sys) begin
    cyc++;
    sckPrev <= sckL;
    if (sckL !== sckPrev) begin
      togs++;
      if (togs > 1 && cyc - lastT < gapMin) gapMin = cyc - lastT;
      if (togs > 1 && cyc - lastT > gapMax) gapMax = cyc - lastT;
      lastT = cyc;
    end
  end
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    k = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    do begin tick(1); k++; end while (hready !== 1'b1 && k < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin tick(1); k++; end while (hready !== 1'b1 && k < 100);
    if (k >= 50) begin n_fail++; end_of_test(); end
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, idx, 32'h0);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, {24'h0, d});
  endtask
  task automatic waitIrq(input logic lvl);
    int k;
    k = 0;
    while (irqReq !== lvl && k < 3000) begin tick(1); k++; end
    if (k == 3000) begin n_fail++; end_of_test(); end
  endtask
  task automatic ack;
    intVectorAck <= 1'b1;
    tick(1);
    intVectorAck <= 1'b0;
  endtask
  // external clock of eight system cycles per bit
  task automatic sm(input logic [7:0] mo, input int nb, output logic [7:0] mi);
    mi = 8'h00;
    for (int b = 0; b < nb; b++) begin
      logic v;
      v = lsb ? mo[b] : mo[7 - b];
      if (!mode[0]) bMosi <= v;
      tick(4);
      if (!mode[0]) mi = lsb ? {misoL, mi[7:1]} : {mi[6:0], misoL};
      bSck <= ~mode[1];
      if (mode[0]) bMosi <= v;
      tick(4);
      if (mode[0]) mi = lsb ? {misoL, mi[7:1]} : {mi[6:0], misoL};
      bSck <= mode[1];
    end
    tick(4);
    bMosi <= ~bMosi;
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(80));
    {nrst, hsel, hwrite, hwdata, haddr, htrans, globalIntEnable, intVectorAck} = '0;
    {bSck, bMosi, mode, lsb, peerTx} = '0;
    bSs = 1'b1;
    hsize = 3'h2;
    tick(2);
    nrst <= 1'b1;
    tick(1);
    rd(CTL, 32'h0);
    rd(STS, 32'h0);
    rd(DIR, 32'h0);
    wr(8'h30, 8'hFF);
    rd(8'h30, 32'h0);
    wr(STS, 8'hFF);
    rd(STS, 32'h1);
    wr(DIR, 8'h0D);
    wr(CTL, 8'h10);
    togs = 0;
    wr(DAT, 8'hA5);
    tick(100);
    check(togs, 0);
    rd(STS, 32'h1);
    globalIntEnable <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      mode = i[1:0];
      lsb = i[2];
      tx = 8'($urandom);
      peerTx = 8'($urandom);
      wr(STS, {7'h0, lsb});
      wr(CTL, {2'b11, lsb, 1'b1, mode, i[1:0]});
      wr(DIR, 8'h1D);
      tick(1);
      check(ssL, 1'b1);
      wr(DIR, 8'h0D);
      togs = 0;
      gapMin = 999;
      gapMax = 0;
      wr(DAT, tx);
      waitIrq(1'b1);
      // Let the edge monitor count the last toggle first
      tick(1);
      check(togs, 16);
      check(gapMin, DIVS[i] / 2);
      check(gapMax, DIVS[i] / 2);
      check(sckL, mode[1]);
      check(peerRx, tx);
      rd(STS, 32'h80 | lsb);
      if (i == 1) begin
        globalIntEnable <= 1'b0;
        tick(2);
        check(irqReq, 1'b0);
        globalIntEnable <= 1'b1;
      end
      if (DIVS[i] > 4) rd(DAT, {24'h0, peerTx});
      else ack();
      rd(STS, {31'h0, lsb});
      check(irqReq, 1'b0);
    end
    mode = 2'h0;
    lsb = 1'b0;
    wr(STS, 8'h00);
    wr(CTL, 8'hD3);
    wr(DIR, 8'h1D);
    wr(DIR, 8'h0D);
    tx = 8'($urandom);
    wr(DAT, tx);
    tick(20);
    wr(DAT, ~tx);
    waitIrq(1'b1);
    check(peerRx, tx);
    rd(STS, 32'hC0);
    rd(DAT, {24'h0, peerTx});
    rd(STS, 32'h0);
    wr(DIR, 8'h05);
    bSs <= 1'b0;
    waitIrq(1'b1);
    check({pinOe.sck, pinOe.mosi}, 2'b00);
    rd(CTL, 32'hC3);
    bSs <= 1'b1;
    tick(10);
    rd(CTL, 32'hC3);
    rd(STS, 32'h80);
    ack();
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      lsb = m[0];
      bSck <= m[1];
      wr(DIR, 8'h0A);
      wr(CTL, {2'b11, lsb, 1'b0, mode, 2'h3});
      tx = 8'($urandom);
      rx = 8'($urandom);
      wr(DAT, tx);
      bSs <= 1'b0;
      tick(8);
      check(pinOe.miso, 1'b1);
      check({pinOe.ss, pinOe.sck, pinOe.mosi}, 3'h0);
      sm(~rx, 3, got);
      bSs <= 1'b1;
      tick(8);
      check(pinOe.miso, 1'b0);
      bSs <= 1'b0;
      tick(8);
      sm(rx, 8, got);
      check(got, tx);
      sm(~rx, 8, got);
      check(got, rx);
      bSs <= 1'b1;
      rd(STS, 32'h80);
      rd(DAT, {24'h0, ~rx});
      rd(STS, 32'h0);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
